/* include/fidr_pkg.sv */
// package with opcodes, identity values and timing for the id/reset command block
package fidr_pkg;
	// command opcodes
	localparam logic [7:0] OP_EXT_PARAM_NV   = 8'h81;
	localparam logic [7:0] OP_LEGACY_SIG     = 8'hAB;
	localparam logic [7:0] OP_STD_ID_SERIAL  = 8'h9F;
	localparam logic [7:0] OP_STD_ID_QUAD    = 8'hAF;
	localparam logic [7:0] OP_MAKER_DEV_ID   = 8'h90;
	localparam logic [7:0] OP_UNIQUE_NUM     = 8'h4B;
	localparam logic [7:0] OP_DISC_PARAM     = 8'h5A;
	localparam logic [7:0] OP_NO_OP          = 8'h00;
	localparam logic [7:0] OP_RESET_ARM      = 8'h66;
	localparam logic [7:0] OP_RESET_DO       = 8'h99;
	// identity values, arbitrary neutral defaults
	localparam logic [7:0]  MAKER_CODE_DEF   = 8'h5C;
	localparam logic [7:0]  DEVICE_CODE_DEF  = 8'h3A;
	localparam logic [15:0] TYPE_DENSITY_DEF = 16'h4C_21;
	// frame bit counts, opcode included, at which each header phase ends
	localparam int HDR_OPC_BITS   = 8;
	localparam int HDR_3DUMMY     = 32;
	localparam int HDR_MDID       = 32;
	localparam int HDR_ADDR_DUMMY = 40;
	// timing, in ns, and derived counts at 100 ns clock
	localparam int CLK_PERIOD_NS        = 100;
	localparam int RESET_PULSE_MIN_NS   = 1000;
	localparam int RESET_RECOVERY_NS    = 100000;
	localparam int RESET_PULSE_CYC      =
		(RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RECOVERY_CYC   =
		(RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// command phases
	typedef enum logic [4:0] {
		PH_OPCODE = 5'b0_0001,
		PH_HEADER = 5'b0_0010,
		PH_OUTPUT = 5'b0_0100,
		PH_IGNORE = 5'b0_1000,
		PH_DONE   = 5'b1_0000
	} fidr_phase_type;
endpackage

/* design/fidr_sync.sv */
// two-flop synchroniser for a single asynchronous level
module fidr_sync
	import fidr_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1_q;
	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage1_q <= RESET_VAL;
			syncOut  <= RESET_VAL;
		end else begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end
endmodule

/* design/fidr_byte_shifter.sv */
// output shifter: loads a byte and presents one bit or nibble per falling edge
module fidr_byte_shifter
	import fidr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] loadByte,
	input  wire logic       shift,
	input  wire logic       quadMode,
	output logic [3:0]      dataOut,
	output logic            byteDone
);
	logic [7:0] sh_q;
	logic [2:0] cnt_q;
	// msb first, one bit per shift in serial, four in quad
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sh_q  <= 8'h00;
			cnt_q <= 3'h0;
		end else if (load) begin
			sh_q  <= loadByte;
			cnt_q <= 3'h0;
		end else if (shift) begin
			sh_q  <= quadMode ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
			cnt_q <= quadMode ? cnt_q + 3'h4 : cnt_q + 3'h1;
		end
	end
	assign dataOut  = quadMode ? sh_q[7:4] : {3'b000, sh_q[7]};
	// last slice of the byte is being shifted
	assign byteDone = shift && (quadMode ? (cnt_q == 3'h4) : (cnt_q == 3'h7));
endmodule

/* design/fidr_core.sv */
// flash identification and reset command interpreter
// Notes on behaviour
// R01: extended param readback returns nonvolatile copy
// R02: signature read: opcode, three dummies, code
// R03: signature repeats until chip enable rises
// R04: standard id: maker then type density
// R05: standard id three bytes loop
// R06: host sends two dummies, one address
// R07: address bit zero picks first byte
// R08: maker and device bytes alternate
// R09: unique read: opcode, address, dummy, sixteen
// R10: sixteen unique bytes repeat continuously
// R11: low address nibble picks start byte
// R12: param read may end anytime
// R13: undefined param addresses return anything
// R14: no-op only disarms reset arm
// R15: reset needs arm frame then reset
// R16: software reset reloads volatile from nonvolatile
// R17: reset pin gating by package options
// R18: reset pin overrides every other input
// R19: reset aborts, wakes, tristates, clears params (pin reset here does not assert releasePowerDown)
// R20: host waits recovery before new commands
// R21: reset aborts program or erase
// R22: status and function registers survive reset
// R23: deep power down accepts only release
// R24: release ignored while write in progress
module fidr_core
	import fidr_pkg::*;
#(
	parameter logic [7:0]   MAKER_CODE   = MAKER_CODE_DEF,
	parameter logic [7:0]   DEVICE_CODE  = DEVICE_CODE_DEF,
	parameter logic [15:0]  TYPE_DENSITY = TYPE_DENSITY_DEF,
	parameter logic [127:0] UNIQUE_NUM   = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
	parameter int           RECOVERY_CYC = RESET_RECOVERY_CYC,
	parameter int           DISC_DEPTH   = 16
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        chipEnable_n,
	input  wire logic        serialClk,
	input  wire logic [3:0]  ioIn,
	output logic [3:0]       ioOut,
	output logic [3:0]       ioOe,
	input  wire logic        hwReset_n,
	input  wire logic        dedicatedResetPkg,
	input  wire logic        resetPinDisable,
	input  wire logic        quadLinesEnableBit,
	input  wire logic        holdOrResetPinSelect,
	input  wire logic        quadMode,
	input  wire logic        deepPowerDown,
	input  wire logic        writeInProgressFlag,
	input  wire logic [7:0]  extParamNv,
	input  wire logic [7:0]  readParamNv,
	output logic [7:0]       readParamVol,
	output logic [7:0]       extParamVol,
	output logic             softResetPulse,
	output logic             hwResetActive,
	output logic             abortWrite,
	output logic             releasePowerDown,
	output logic             resetArmed,
	output logic             recovering
);
	// refuse parameter values the logic cannot serve
	if (DISC_DEPTH < 1 || DISC_DEPTH > 256) begin : gDepthCheck
		$error("DISC_DEPTH out of range");
	end
	if (RECOVERY_CYC < 1 || RECOVERY_CYC > 131071) begin : gRecovCheck
		$error("RECOVERY_CYC must fit the 17-bit recovery counter");
	end

	logic            ce_n, sck, rstPin_n;
	logic [3:0]      io;
	logic            sckPrev_q;
	logic            sckRise, sckFall;
	fidr_phase_type  phase_q;
	logic [7:0]      opcode_q;
	logic [5:0]      bitCnt_q;
	logic [23:0]     addr_q;
	logic [3:0]      byteIdx_q;
	logic            shLoad, shShift, shByteDone;
	logic [7:0]      nextByte;
	logic [3:0]      shData;
	logic            outEn_q;
	logic            byteDone_q;
	logic            hwResetEff;
	logic            frameEnd;
	logic [7:0]      discTable [DISC_DEPTH];
	logic [16:0]     recovCnt_q;
	logic [7:0]      gotOp;
	logic [5:0]      hdrBits;
	logic [2:0]      step;

	// synchronise every pin before use
	fidr_sync #(.RESET_VAL(1'b1)) uCe  (.core_clk(core_clk), .rst_n(rst_n),
		.asyncIn(chipEnable_n), .syncOut(ce_n));
	fidr_sync #(.RESET_VAL(1'b0)) uSck (.core_clk(core_clk), .rst_n(rst_n),
		.asyncIn(serialClk), .syncOut(sck));
	fidr_sync #(.RESET_VAL(1'b1)) uRst (.core_clk(core_clk), .rst_n(rst_n),
		.asyncIn(hwReset_n), .syncOut(rstPin_n));
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : gIo
			fidr_sync #(.RESET_VAL(1'b0)) uIo (.core_clk(core_clk), .rst_n(rst_n),
				.asyncIn(ioIn[gi]), .syncOut(io[gi]));
		end
	endgenerate

	// pin reset gating by package and mode
	assign hwResetEff = !rstPin_n && (dedicatedResetPkg ? !resetPinDisable   // R17
		: (!quadMode && !quadLinesEnableBit && holdOrResetPinSelect));    // R17
	assign hwResetActive = hwResetEff;

	// serial clock edge detect
	always_ff @(posedge core_clk) begin
		if (!rst_n) sckPrev_q <= 1'b0;
		else        sckPrev_q <= sck;
	end
	assign sckRise  = sck && !sckPrev_q && !ce_n;
	assign sckFall  = !sck && sckPrev_q && !ce_n;
	assign frameEnd = ce_n && (phase_q != PH_OPCODE);

	// header length per opcode
	always_comb begin
		case (opcode_q)
			OP_LEGACY_SIG:   hdrBits = 6'(HDR_3DUMMY);     // R02
			OP_MAKER_DEV_ID: hdrBits = 6'(HDR_MDID);       // R06
			OP_UNIQUE_NUM,
			OP_DISC_PARAM:   hdrBits = 6'(HDR_ADDR_DUMMY); // R09 R12
			default:         hdrBits = 6'(HDR_OPC_BITS);
		endcase
	end
	assign step  = quadMode ? 3'h4 : 3'h1;
	assign gotOp = quadMode ? {opcode_q[3:0], io} : {opcode_q[6:0], io[0]};

	// disc table content, unspecified entries return anything
	always_comb begin
		for (int k = 0; k < DISC_DEPTH; k++) discTable[k] = 8'(k);     // R13
	end

	// next output byte from command and index
	always_comb begin
		case (opcode_q)
			OP_EXT_PARAM_NV: nextByte = extParamNv;                   // R01
			OP_LEGACY_SIG:   nextByte = DEVICE_CODE;                  // R03
			OP_STD_ID_SERIAL,
			OP_STD_ID_QUAD: begin
				case (byteIdx_q[1:0])                                 // R04
					2'd0:    nextByte = MAKER_CODE;
					2'd1:    nextByte = TYPE_DENSITY[15:8];
					default: nextByte = TYPE_DENSITY[7:0];
				endcase
			end
			OP_MAKER_DEV_ID:                                          // R07
				nextByte = (byteIdx_q[0] ^ addr_q[0]) ? DEVICE_CODE : MAKER_CODE;
			OP_UNIQUE_NUM:
				nextByte = UNIQUE_NUM[8'(127 - 8 * int'(byteIdx_q)) -: 8]; // R09
			OP_DISC_PARAM:
				nextByte = discTable[(int'(addr_q[7:0]) + int'(byteIdx_q)) % DISC_DEPTH];
			default:         nextByte = 8'h00;
		endcase
	end

	// command phase sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff) begin                              // R18
			phase_q  <= PH_OPCODE;
			opcode_q <= 8'h00;
			bitCnt_q <= 6'd0;
			addr_q   <= 24'h00_0000;
		end else if (ce_n) begin                                     // R12
			phase_q  <= PH_OPCODE;
			bitCnt_q <= 6'd0;
		end else if (sckRise) begin
			case (phase_q)
				PH_OPCODE: begin
					opcode_q <= gotOp;
					bitCnt_q <= bitCnt_q + 6'(step);
					if (bitCnt_q + 6'(step) == 6'(HDR_OPC_BITS)) begin
						if (recovering)                                // R20
							phase_q <= PH_IGNORE;
						else if (deepPowerDown && gotOp != OP_LEGACY_SIG)
							phase_q <= PH_IGNORE;                      // R23
						else if (gotOp == OP_LEGACY_SIG && writeInProgressFlag)
							phase_q <= PH_IGNORE;                      // R24
						else if (gotOp inside {OP_EXT_PARAM_NV, OP_STD_ID_SERIAL,
								OP_STD_ID_QUAD})
							phase_q <= PH_OUTPUT;
						else if (gotOp inside {OP_LEGACY_SIG, OP_MAKER_DEV_ID,
								OP_UNIQUE_NUM, OP_DISC_PARAM})
							phase_q <= PH_HEADER;
						else
							phase_q <= PH_DONE;
					end
				end
				PH_HEADER: begin
					bitCnt_q <= bitCnt_q + 6'(step);
					if (bitCnt_q < 6'd32)
						addr_q <= quadMode ? {addr_q[19:0], io} : {addr_q[22:0], io[0]};
					if (bitCnt_q + 6'(step) == hdrBits)
						phase_q <= PH_OUTPUT;
				end
				PH_OUTPUT, PH_IGNORE, PH_DONE: ;
				default: phase_q <= PH_OPCODE;
			endcase
		end
	end

	// mdid address sits in the last header byte
	// output byte index, wraps per command
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff || ce_n) begin
			byteIdx_q <= 4'h0;
		end else if (phase_q == PH_HEADER && sckRise && bitCnt_q + 6'(step) == hdrBits) begin
			byteIdx_q <= (opcode_q == OP_UNIQUE_NUM) ? addr_q[3:0] : 4'h0;  // R11
		end else if (shByteDone) begin
			case (opcode_q)
				OP_STD_ID_SERIAL, OP_STD_ID_QUAD:                        // R05
					byteIdx_q <= (byteIdx_q == 4'h2) ? 4'h0 : byteIdx_q + 4'h1;
				OP_MAKER_DEV_ID: byteIdx_q <= {3'b000, ~byteIdx_q[0]};  // R08
				default:         byteIdx_q <= byteIdx_q + 4'h1;          // R10
			endcase
		end
	end

	// reload one cycle after a byte ends, once the index has moved on
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff || ce_n)
			byteDone_q <= 1'b0;
		else
			byteDone_q <= shByteDone;
	end

	// shifter preloads until the first falling edge, then after each byte
	assign shLoad  = (phase_q != PH_OUTPUT) || !outEn_q || byteDone_q;
	assign shShift = (phase_q == PH_OUTPUT) && sckFall;
	fidr_byte_shifter uShift (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (shLoad && !shShift),
		.loadByte (nextByte),
		.shift    (shShift),
		.quadMode (quadMode),
		.dataOut  (shData),
		.byteDone (shByteDone)
	);

	// output enable opens on first falling edge of output phase
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff || ce_n)                           // R19
			outEn_q <= 1'b0;
		else if (phase_q == PH_OUTPUT && sckFall)
			outEn_q <= 1'b1;
	end
	// pins driven only while output active
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff) begin
			ioOut <= 4'h0;
			ioOe  <= 4'h0;
		end else if (ce_n || phase_q != PH_OUTPUT) begin
			ioOe  <= 4'h0;
		end else if (sckFall) begin
			ioOut <= quadMode ? shData : {2'b00, shData[0], 1'b0};
			ioOe  <= quadMode ? 4'hF : 4'h2;
		end
	end

	// reset arm latch, cleared at the end of any other frame past its opcode that is not ignored
	always_ff @(posedge core_clk) begin
		if (!rst_n || hwResetEff)
			resetArmed <= 1'b0;
		else if (frameEnd && phase_q == PH_DONE && opcode_q == OP_RESET_ARM)
			resetArmed <= 1'b1;                                      // R15
		else if (frameEnd && phase_q != PH_IGNORE)
			resetArmed <= 1'b0;                                      // R14 R15
	end
	assign softResetPulse = frameEnd && phase_q == PH_DONE
		&& opcode_q == OP_RESET_DO && resetArmed;                    // R15

	// release from power down on a bare release frame
	assign releasePowerDown = frameEnd && deepPowerDown && opcode_q == OP_LEGACY_SIG
		&& phase_q != PH_IGNORE;
	// a software reset or a gated pin reset aborts a write in progress, rst_n does not
	assign abortWrite = (softResetPulse || hwResetEff) && writeInProgressFlag; // R21

	// volatile parameter copies, status/function untouched here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			readParamVol <= 8'h00;
			extParamVol  <= 8'h00;
		end else if (softResetPulse || hwResetEff) begin             // R16 R19 R22
			readParamVol <= readParamNv;
			extParamVol  <= extParamNv;
		end
	end

	// recovery count after pin reset
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			recovCnt_q <= 17'd0;
		else if (hwResetEff)
			recovCnt_q <= 17'(RECOVERY_CYC);                         // R20
		else if (recovCnt_q != 17'd0)
			recovCnt_q <= recovCnt_q - 17'd1;
	end
	assign recovering = (recovCnt_q != 17'd0);

	// checks on the command and reset behaviour
	sequence armFrame_s;
		frameEnd && phase_q == PH_DONE && opcode_q == OP_RESET_ARM;
	endsequence
	pin_tristate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
		hwResetEff |=> ioOe == 4'h0) else $error("outputs driven during reset");
	arm_sets_a: assert property (@(posedge core_clk) disable iff (!rst_n)  // R15
		(armFrame_s and !hwResetEff) |=> resetArmed) else $error("arm not latched");
	soft_reload_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
		softResetPulse |=> readParamVol == $past(readParamNv))
		else $error("volatile not reloaded");
	dpd_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R23
		deepPowerDown && phase_q == PH_IGNORE |-> ioOe == 4'h0)
		else $error("driven in power down");
	recov_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
		hwResetEff |=> recovering) else $error("no recovery after reset");
	abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)     // R21
		hwResetEff && writeInProgressFlag |-> abortWrite) else $error("no abort");
	idx_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)  // R05
		opcode_q == OP_STD_ID_SERIAL |-> byteIdx_q <= 4'h2)
		else $error("standard id index overrun");
	mdid_alt_a: assert property (@(posedge core_clk) disable iff (!rst_n)  // R08
		opcode_q == OP_MAKER_DEV_ID && shByteDone && !ce_n
		|=> byteIdx_q[0] != $past(byteIdx_q[0])) else $error("no alternation");
	sequence nopFrame_s;
		frameEnd && phase_q == PH_DONE && opcode_q == OP_NO_OP;
	endsequence
	nop_only_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		(nopFrame_s and !hwResetEff) |=> !resetArmed && readParamVol == $past(readParamVol))
		else $error("no-op did more than disarm");
	recov_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
		recovering && phase_q == PH_IGNORE |-> ioOe == 4'h0)
		else $error("driven while recovering");
	oe_width_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R02 R04
		outEn_q |-> ioOe == (quadMode ? 4'hF : 4'h2))
		else $error("output enable does not match mode");
endmodule

/* tb/fidr_host_model.sv */
// host controller model: frames commands on chip enable, serial clock and data lines
module fidr_host_model
	import fidr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       quadMode,
	input  wire logic [3:0] ioOut,
	input  wire logic [3:0] ioOe,
	output logic            chipEnable_n,
	output logic            serialClk,
	output logic [3:0]      ioIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] lastOe;
	// idle lines at time zero, serial clock parked low between frames
	initial begin
		chipEnable_n = 1'b1;
		serialClk = 1'b0;
		ioIn = 4'h0;
		lastOe = 4'h0;
	end
	// half a serial clock period, 400 ns
	task automatic half();
		repeat (4) @(posedge core_clk);
	endtask
	// one frame: opcode and header on rising edges, then output captured before each rise
	task automatic frame(input logic [7:0] op, input logic [31:0] hdr, input int hdrBits,
		input int outBits, output logic [127:0] got);
		logic [39:0] sh;
		int          step;
		sh = {op, hdr};
		got = '0;
		@(posedge core_clk);
		step = quadMode ? 4 : 1;
		chipEnable_n <= 1'b0;
		half();
		for (int i = 0; i < 8 + hdrBits; i += step) begin
			ioIn <= quadMode ? sh[39 -: 4] : {3'b000, sh[39]};
			sh = sh << step;
			half();
			serialClk <= 1'b1;
			half();
			serialClk <= 1'b0;
		end
		ioIn <= ~ioIn; // released lines stop showing the last value
		for (int i = 0; i < outBits; i += step) begin
			half();
			// an undriven pin reads as the inverse of the last driven value
			got = quadMode ? {got[123:0], ioOut ~^ ioOe}
				: {got[126:0], ioOut[1] ~^ ioOe[1]};
			lastOe = ioOe;
			serialClk <= 1'b1;
			half();
			serialClk <= 1'b0;
		end
		half();
		chipEnable_n <= 1'b1;
		repeat (8) half(); // one command per frame, idle gap between
	endtask
endmodule

/* tb/fidr_core_tb.sv */
// self-checking bench for the id and reset command interpreter
module fidr_core_tb
	import fidr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [7:0]   op;
		logic [31:0]  hdr;
		int           hdrBits;
		int           outBits;
		logic [127:0] exp;
	} fidr_row_type;
	localparam logic [127:0] UNQ = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
	localparam int LIMIT = 60000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic chipEnable_n, serialClk;
	logic [3:0] ioIn, ioOut, ioOe;
	logic hwReset_n = 1'b1;
	logic dedicatedResetPkg = 1'b1;
	logic resetPinDisable = 1'b0;
	logic quadLinesEnableBit = 1'b0;
	logic holdOrResetPinSelect = 1'b0;
	logic quadMode = 1'b0;
	logic deepPowerDown = 1'b0;
	logic writeInProgressFlag = 1'b0;
	logic [7:0] extParamNv = 8'hC3;
	logic [7:0] readParamNv = 8'h5A;
	logic [7:0] readParamVol, extParamVol;
	logic softResetPulse, hwResetActive, abortWrite, releasePowerDown, resetArmed, recovering;
	int nFail = 0;
	int comparisons = 0;
	int cycles = 0;
	int cntSoft = 0, cntRel = 0, cntHw = 0, cntAbort = 0, cntRec = 0;
	int s;
	logic [127:0] got, m;
	fidr_row_type rows[8];
	logic [4:0] cfg[3];

	fidr_core #(.UNIQUE_NUM(UNQ), .RECOVERY_CYC(200)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .chipEnable_n(chipEnable_n),
		.serialClk(serialClk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
		.hwReset_n(hwReset_n), .dedicatedResetPkg(dedicatedResetPkg),
		.resetPinDisable(resetPinDisable), .quadLinesEnableBit(quadLinesEnableBit),
		.holdOrResetPinSelect(holdOrResetPinSelect), .quadMode(quadMode),
		.deepPowerDown(deepPowerDown), .writeInProgressFlag(writeInProgressFlag),
		.extParamNv(extParamNv), .readParamNv(readParamNv), .readParamVol(readParamVol),
		.extParamVol(extParamVol), .softResetPulse(softResetPulse),
		.hwResetActive(hwResetActive), .abortWrite(abortWrite),
		.releasePowerDown(releasePowerDown), .resetArmed(resetArmed),
		.recovering(recovering));

	fidr_host_model i_host (
		.core_clk(core_clk), .quadMode(quadMode), .ioOut(ioOut), .ioOe(ioOe),
		.chipEnable_n(chipEnable_n), .serialClk(serialClk), .ioIn(ioIn));

	// 10 MHz core clock
	always #50 core_clk = ~core_clk;

	// pulse counters and hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		cntSoft <= cntSoft + int'(softResetPulse === 1'b1);
		cntRel <= cntRel + int'(releasePowerDown === 1'b1);
		cntHw <= cntHw + int'(hwResetActive === 1'b1);
		cntAbort <= cntAbort + int'(abortWrite === 1'b1);
		cntRec <= cntRec + int'(recovering === 1'b1);
		if (cycles == LIMIT) begin
			nFail++;
			$display("unexpected at %0t: run did not finish", $time);
			summarize();
		end
	end

	// compare one value, count and report
	task automatic check(input logic [127:0] g, input logic [127:0] e, input string what);
		comparisons++;
		if (g !== e) begin
			nFail++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask

	// pin reset pulse, then wait past the synchronisers
	task automatic pinReset();
		@(posedge core_clk);
		hwReset_n <= 1'b0;
		repeat (RESET_PULSE_CYC + 2) @(posedge core_clk);
		hwReset_n <= 1'b1;
		repeat (60) @(posedge core_clk);
	endtask

	// verdict and end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, nFail);
		if (nFail == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		rows[0] = '{OP_EXT_PARAM_NV, 32'h0, 0, 8, 128'h00C3};
		rows[1] = '{OP_LEGACY_SIG, 32'h0, 24, 16, {DEVICE_CODE_DEF, DEVICE_CODE_DEF}};
		rows[2] = '{OP_STD_ID_SERIAL, 32'h0, 0, 32, {MAKER_CODE_DEF, TYPE_DENSITY_DEF,
			MAKER_CODE_DEF}};
		rows[3] = '{OP_MAKER_DEV_ID, 32'h0, 24, 24, {MAKER_CODE_DEF, DEVICE_CODE_DEF,
			MAKER_CODE_DEF}};
		rows[4] = '{OP_MAKER_DEV_ID, 32'h0000_0100, 24, 24, {DEVICE_CODE_DEF, MAKER_CODE_DEF,
			DEVICE_CODE_DEF}};
		rows[5] = '{OP_UNIQUE_NUM, 32'h0, 32, 128, UNQ};
		rows[6] = '{OP_UNIQUE_NUM, 32'h0000_0300, 32, 128, {UNQ[103:0], UNQ[127:104]}};
		rows[7] = '{OP_DISC_PARAM, 32'h0000_0200, 32, 16, 128'h0203};
		cfg[0] = 5'b1_0001; // dedicated pin enabled: acts
		cfg[1] = 5'b0_0110; // shared pin with quad lines enabled: no action
		cfg[2] = 5'b0_0011; // shared pin selected, quad lines off: acts
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		check(readParamVol, 8'h00, "volatile param at reset");
		foreach (rows[i]) begin
			i_host.frame(rows[i].op, rows[i].hdr, rows[i].hdrBits, rows[i].outBits, got);
			m = (rows[i].outBits == 128) ? '1 : ((128'h1 << rows[i].outBits) - 1);
			check(got & m, rows[i].exp, "id readout");
			check(i_host.lastOe, 4'h2, "serial output enable");
		end
		// quad-mode standard id
		@(posedge core_clk);
		quadMode <= 1'b1;
		i_host.frame(OP_STD_ID_QUAD, 32'h0, 0, 24, got);
		check(got[23:0], {MAKER_CODE_DEF, TYPE_DENSITY_DEF}, "quad id");
		check(i_host.lastOe, 4'hF, "quad output enable");
		quadMode <= 1'b0;
		// arm, cancel by no-op, cancel by other command, then execute
		i_host.frame(OP_RESET_ARM, 32'h0, 0, 0, got);
		check(resetArmed, 1'b1, "armed");
		i_host.frame(OP_NO_OP, 32'h0, 0, 0, got);
		check(resetArmed, 1'b0, "no-op disarm");
		i_host.frame(OP_RESET_ARM, 32'h0, 0, 0, got);
		i_host.frame(OP_STD_ID_SERIAL, 32'h0, 0, 8, got);
		check(resetArmed, 1'b0, "other command disarm");
		s = cntSoft;
		i_host.frame(OP_RESET_DO, 32'h0, 0, 0, got);
		check(cntSoft, s, "reset without arm");
		i_host.frame(OP_RESET_ARM, 32'h0, 0, 0, got);
		i_host.frame(OP_RESET_DO, 32'h0, 0, 0, got);
		check(cntSoft, s + 1, "software reset");
		check({readParamVol, extParamVol}, {readParamNv, extParamNv}, "reload");
		// deep power down: only release accepted, not while writing
		deepPowerDown <= 1'b1;
		i_host.lastOe = 4'h0;
		i_host.frame(OP_STD_ID_SERIAL, 32'h0, 0, 8, got);
		check(i_host.lastOe, 4'h0, "ignored in power down");
		s = cntRel;
		writeInProgressFlag <= 1'b1;
		i_host.frame(OP_LEGACY_SIG, 32'h0, 0, 0, got);
		check(cntRel, s, "release while writing");
		writeInProgressFlag <= 1'b0;
		i_host.frame(OP_LEGACY_SIG, 32'h0, 0, 0, got);
		check(cntRel, s + 1, "release");
		deepPowerDown <= 1'b0;
		// pin reset under each package option
		for (int k = 0; k < 3; k++) begin
			{dedicatedResetPkg, resetPinDisable, quadLinesEnableBit, holdOrResetPinSelect} <=
				cfg[k][4:1];
			writeInProgressFlag <= 1'b1;
			s = cntHw;
			pinReset();
			check(cntHw > s, cfg[k][0], "pin reset gating");
		end
		writeInProgressFlag <= 1'b0;
		check(cntAbort > 0, 1'b1, "write aborted");
		// a command inside the recovery time is ignored, one after it answers
		i_host.lastOe = 4'h0;
		i_host.frame(OP_STD_ID_SERIAL, 32'h0, 0, 8, got);
		check(i_host.lastOe, 4'h0, "ignored while recovering");
		repeat (200) @(posedge core_clk);
		check(cntRec >= 200, 1'b1, "recovery ran");
		check(recovering, 1'b0, "recovery ended");
		i_host.frame(OP_LEGACY_SIG, 32'h0, 24, 8, got);
		check(got[7:0], DEVICE_CODE_DEF, "accepted after recovery");
		summarize();
	end
endmodule
